// file: shared/sfsr_pkg.sv
// constants and carrier types for the sensor fault status register bank
// assumes a single 100 MHz device clock shared by every user of this package
`default_nettype none

package sfsr_pkg;

    // ****************************************
    // register offsets
    // ****************************************
    localparam logic [7:0] SFSR_OFS_SUMMARY  = 8'h01;
    localparam logic [7:0] SFSR_OFS_MEMTEMP  = 8'h03;
    localparam logic [7:0] SFSR_OFS_LINK     = 8'h04;
    localparam logic [7:0] SFSR_OFS_THERMAL  = 8'h0e;

    // ****************************************
    // field positions
    // ****************************************
    localparam int SFSR_BIT_F_OTP       = 7;
    localparam int SFSR_BIT_U_OTP       = 6;
    localparam int SFSR_BIT_U_RW        = 5;
    localparam int SFSR_BIT_U_W_ACTIVE  = 4;
    localparam int SFSR_BIT_THERMAL     = 2;
    localparam int SFSR_BIT_MISO        = 7;
    localparam int SFSR_BIT_SUM_MEMTEMP = 4;
    localparam int SFSR_BIT_SUM_LINK    = 5;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [7:0] SFSR_RST_BYTE  = 8'h00;
    localparam logic       SFSR_RST_FLAG  = 1'b0;

    // ****************************************
    // timing
    // ****************************************
    localparam int SFSR_CLK_MHZ           = 100;
    localparam int SFSR_SUP_RECOVERY_US   = 10;
    localparam int SFSR_SUP_RECOVERY_CYC  = SFSR_SUP_RECOVERY_US * SFSR_CLK_MHZ;
    localparam int SFSR_TIMER_W           = 16;
    localparam int SFSR_USER_BYTES        = 8;

    // ****************************************
    // carrier types
    // ****************************************
    typedef struct packed {
        logic f_otp_fault;
        logic u_otp_fault;
        logic miso_mismatch;
    } sfsr_event_s;

    typedef struct packed {
        logic memtemp;
        logic link;
    } sfsr_txclr_s;

endpackage : sfsr_pkg

`default_nettype wire

// file: hdl/sfsr_regs.sv
// read-only fault and die temperature registers of the pressure sensor
// assumes the serial front end decodes reads and feeds events on MCLK;
// only the supply fault input comes from another domain
// Functional notes
// - factory array fault sets memory bit 7
// - user array fault sets memory bit 6
// - after lock, check code recomputed and compared
// - check code mismatch sets memory bit 5
// - read or status transmission clears sticky bits
// - bit 4 follows active user array write
// - thermal range fault sets memory bit 2
// - readback mismatch sets link bit 7
// - read or status transmission clears link bit
// - 8-bit die temperature, zero after reset
// - one supply recovery timer reloaded during fault
// - MEMORY_THERMAL_SUMMARY output ORs memory bits; the summary offset reads zero
// - LINK_FAULT_SUMMARY output mirrors link flag
// - lock bit clears only on reset
`timescale 1ns/100ps
`default_nettype none

module sfsr_regs (
    input  wire logic                                             MCLK,
    input  wire logic                                             RESET,
    input  wire logic                                             CLK_EN,
    input  wire logic                                             REG_RD,
    input  wire logic [7:0]                                       REG_ADDR,
    output var  logic [7:0]                                       REG_RDATA,
    input  wire sfsr_pkg::sfsr_event_s                            EVENTS,
    input  wire sfsr_pkg::sfsr_txclr_s                            TX_CLEAR,
    input  wire logic                                             U_OTP_WR_BUSY,
    input  wire logic                                             THERMAL_RANGE_FAULT,
    input  wire logic [7:0]                                       DIE_TEMP,
    input  wire logic                                             DIE_TEMP_VALID,
    input  wire logic                                             INIT_LOCK_SET,
    input  wire logic [sfsr_pkg::SFSR_USER_BYTES*8-1:0]           USER_REGS,
    input  wire logic                                             SUPPLY_FAULT,
    output var  logic                                             INIT_COMPLETE_LOCK,
    output var  logic                                             MEMORY_THERMAL_SUMMARY,
    output var  logic                                             LINK_FAULT_SUMMARY,
    output var  logic                                             SUPPLY_RECOVERING
);

    // ****************************************
    // helpers
    // ****************************************
    // rotate-and-xor fold: cheap, catches any single-bit flip in the array
    function automatic logic [7:0] check_code(input logic [sfsr_pkg::SFSR_USER_BYTES*8-1:0] img);
        logic [7:0] acc;
        acc = 8'h00;
        for (int i = 0; i < sfsr_pkg::SFSR_USER_BYTES; i++) begin
            acc = {acc[6:0], acc[7]} ^ img[i*8 +: 8];
        end
        return acc;
    endfunction : check_code

    function automatic logic sticky(input logic cur, input logic clr, input logic set);
        return (cur & ~clr) | set;
    endfunction : sticky

    // ****************************************
    // state
    // ****************************************
    logic       f_otp;
    logic       u_otp;
    logic       u_rw;
    logic       u_w_active;
    logic       thermal;
    logic       miso;
    logic [7:0] die_temp;
    logic [7:0] stored_code;
    logic       sup_s1;
    logic       sup_s2;
    logic       sup_s3;
    logic       sup_level;
    logic [sfsr_pkg::SFSR_TIMER_W-1:0] sup_timer;

    logic       rd_mem;
    logic       rd_link;
    logic       clr_mem;
    logic       clr_link;
    logic       rw_mismatch;
    logic       next_f_otp;
    logic       next_u_otp;
    logic       next_u_rw;
    logic       next_thermal;
    logic       next_miso;
    logic [7:0] mem_byte;
    logic [7:0] link_byte;

    // ****************************************
    // clear and set terms
    // ****************************************
    always_comb begin
        rd_mem       = REG_RD && (REG_ADDR == sfsr_pkg::SFSR_OFS_MEMTEMP);
        rd_link      = REG_RD && (REG_ADDR == sfsr_pkg::SFSR_OFS_LINK);
        clr_mem      = rd_mem | TX_CLEAR.memtemp;
        clr_link     = rd_link | TX_CLEAR.link;
        rw_mismatch  = INIT_COMPLETE_LOCK && (check_code(USER_REGS) != stored_code);
    end

    // ****************************************
    // next flag values
    // ****************************************
    // set wins over a clear in the same cycle so no event is lost
    always_comb begin
        next_f_otp   = sticky(f_otp, clr_mem, EVENTS.f_otp_fault);
        next_u_otp   = sticky(u_otp, clr_mem, EVENTS.u_otp_fault);
        next_u_rw    = sticky(u_rw, clr_mem, rw_mismatch);
        next_thermal = sticky(thermal, clr_mem, THERMAL_RANGE_FAULT);
        next_miso    = sticky(miso, clr_link, EVENTS.miso_mismatch);
    end

    // ****************************************
    // read bytes
    // ****************************************
    // reserved positions stay tied low
    always_comb begin
        mem_byte = 8'h00;
        mem_byte[sfsr_pkg::SFSR_BIT_F_OTP]      = f_otp;
        mem_byte[sfsr_pkg::SFSR_BIT_U_OTP]      = u_otp;
        mem_byte[sfsr_pkg::SFSR_BIT_U_RW]       = u_rw;
        mem_byte[sfsr_pkg::SFSR_BIT_U_W_ACTIVE] = u_w_active;
        mem_byte[sfsr_pkg::SFSR_BIT_THERMAL]    = thermal;
        link_byte = 8'h00;
        link_byte[sfsr_pkg::SFSR_BIT_MISO] = miso;
    end

    // ****************************************
    // factory array flag
    // ****************************************
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            f_otp <= sfsr_pkg::SFSR_RST_FLAG;
        end else if (CLK_EN) begin
            f_otp <= next_f_otp;
        end
    end

    // ****************************************
    // user array flag
    // ****************************************
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            u_otp <= sfsr_pkg::SFSR_RST_FLAG;
        end else if (CLK_EN) begin
            u_otp <= next_u_otp;
        end
    end

    // ****************************************
    // user register integrity flag
    // ****************************************
    // re-sets every cycle the image differs, so a read only clears it once repaired
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            u_rw <= sfsr_pkg::SFSR_RST_FLAG;
        end else if (CLK_EN) begin
            u_rw <= next_u_rw;
        end
    end

    // ****************************************
    // user array write activity
    // ****************************************
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            u_w_active <= sfsr_pkg::SFSR_RST_FLAG;
        end else if (CLK_EN) begin
            u_w_active <= U_OTP_WR_BUSY; // live level, reads do not touch it
        end
    end

    // ****************************************
    // thermal range flag
    // ****************************************
    // sticky: a brief excursion stays visible until the host looks
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            thermal <= sfsr_pkg::SFSR_RST_FLAG;
        end else if (CLK_EN) begin
            thermal <= next_thermal;
        end
    end

    // ****************************************
    // link flag
    // ****************************************
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            miso <= sfsr_pkg::SFSR_RST_FLAG;
        end else if (CLK_EN) begin
            miso <= next_miso;
        end
    end

    // ****************************************
    // memory summary output
    // ****************************************
    // registered from next values so the summary tracks the flags without lag
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            MEMORY_THERMAL_SUMMARY <= sfsr_pkg::SFSR_RST_FLAG;
        end else if (CLK_EN) begin
            MEMORY_THERMAL_SUMMARY <= next_f_otp | next_u_otp | next_u_rw
                                      | U_OTP_WR_BUSY | next_thermal;
        end
    end

    // ****************************************
    // link summary output
    // ****************************************
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            LINK_FAULT_SUMMARY <= sfsr_pkg::SFSR_RST_FLAG;
        end else if (CLK_EN) begin
            LINK_FAULT_SUMMARY <= next_miso;
        end
    end

    // ****************************************
    // initialization lock
    // ****************************************
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            INIT_COMPLETE_LOCK <= sfsr_pkg::SFSR_RST_FLAG;
        end else if (CLK_EN && INIT_LOCK_SET) begin
            INIT_COMPLETE_LOCK <= 1'b1; // no path back to zero but reset
        end
    end

    // ****************************************
    // reference check code
    // ****************************************
    // snapshot taken once: a later lock request must not re-learn a corrupted image
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            stored_code <= sfsr_pkg::SFSR_RST_BYTE;
        end else if (CLK_EN && INIT_LOCK_SET && !INIT_COMPLETE_LOCK) begin
            stored_code <= check_code(USER_REGS);
        end
    end

    // ****************************************
    // die temperature
    // ****************************************
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            die_temp <= sfsr_pkg::SFSR_RST_BYTE;
        end else if (CLK_EN && DIE_TEMP_VALID) begin
            die_temp <= DIE_TEMP;
        end
    end

    // ****************************************
    // supply fault synchroniser
    // ****************************************
    // first stage read only by the second; level taken once stages two and three agree
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            sup_s1    <= 1'b0;
            sup_s2    <= 1'b0;
            sup_s3    <= 1'b0;
            sup_level <= 1'b0;
        end else if (CLK_EN) begin
            sup_s1 <= SUPPLY_FAULT;
            sup_s2 <= sup_s1;
            sup_s3 <= sup_s2;
            if (sup_s2 == sup_s3) begin
                sup_level <= sup_s3;
            end
        end
    end

    // ****************************************
    // supply recovery timer
    // ****************************************
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            sup_timer         <= '0;
            SUPPLY_RECOVERING <= 1'b0;
        end else if (CLK_EN) begin
            if (sup_level) begin
                sup_timer         <= sfsr_pkg::SFSR_TIMER_W'(sfsr_pkg::SFSR_SUP_RECOVERY_CYC);
                SUPPLY_RECOVERING <= 1'b1;
            end else if (sup_timer != '0) begin
                sup_timer         <= sup_timer - 1'b1;
                SUPPLY_RECOVERING <= (sup_timer != sfsr_pkg::SFSR_TIMER_W'(1));
            end else begin
                SUPPLY_RECOVERING <= 1'b0;
            end
        end
    end

    // ****************************************
    // read port
    // ****************************************
    // no write path exists: host writes to these offsets fall on the floor
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            REG_RDATA <= sfsr_pkg::SFSR_RST_BYTE;
        end else if (CLK_EN && REG_RD) begin
            unique case (REG_ADDR)
                sfsr_pkg::SFSR_OFS_MEMTEMP: REG_RDATA <= mem_byte;
                sfsr_pkg::SFSR_OFS_LINK:    REG_RDATA <= link_byte;
                sfsr_pkg::SFSR_OFS_THERMAL: REG_RDATA <= die_temp;
                default:                    REG_RDATA <= 8'h00;
            endcase
        end
    end

endmodule : sfsr_regs

`default_nettype wire

// file: dv/sfsr_checker.sv
// assertions on the fault status bank ports
// assumes one MCLK domain; bound to sfsr_regs below
`timescale 1ns/100ps
`default_nettype none
module sfsr_checker (
    input wire logic                  MCLK,
    input wire logic                  RESET,
    input wire logic                  CLK_EN,
    input wire sfsr_pkg::sfsr_event_s EVENTS,
    input wire sfsr_pkg::sfsr_txclr_s TX_CLEAR,
    input wire logic                  U_OTP_WR_BUSY,
    input wire logic                  THERMAL_RANGE_FAULT,
    input wire logic                  INIT_LOCK_SET,
    input wire logic                  SUPPLY_FAULT,
    input wire logic                  INIT_COMPLETE_LOCK,
    input wire logic                  MEMORY_THERMAL_SUMMARY,
    input wire logic                  LINK_FAULT_SUMMARY,
    input wire logic                  SUPPLY_RECOVERING
);
    // ********
    // properties
    // ********
    default clocking @(posedge MCLK); endclocking
    default disable iff (RESET);
    // five samples cover the 4 edge synchroniser plus the output flop
    sequence s_sup_held;
        (CLK_EN && SUPPLY_FAULT)[*5];
    endsequence
    sequence s_mem_quiet;
        !EVENTS.f_otp_fault && !EVENTS.u_otp_fault && !U_OTP_WR_BUSY && !THERMAL_RANGE_FAULT;
    endsequence
    AST_FOTP: assert property (CLK_EN && EVENTS.f_otp_fault |=> MEMORY_THERMAL_SUMMARY)
        else $error("factory fault not summarised");
    AST_UOTP: assert property (CLK_EN && EVENTS.u_otp_fault |=> MEMORY_THERMAL_SUMMARY)
        else $error("user fault not summarised");
    AST_THERM: assert property (CLK_EN && THERMAL_RANGE_FAULT |=> MEMORY_THERMAL_SUMMARY)
        else $error("thermal fault not summarised");
    AST_BUSY: assert property (CLK_EN && U_OTP_WR_BUSY |=> MEMORY_THERMAL_SUMMARY)
        else $error("write busy not summarised");
    AST_MISO: assert property (CLK_EN && EVENTS.miso_mismatch |=> LINK_FAULT_SUMMARY)
        else $error("link fault not summarised");
    AST_LINKCLR: assert property (CLK_EN && TX_CLEAR.link && !EVENTS.miso_mismatch |=> !LINK_FAULT_SUMMARY)
        else $error("link flag survived clear");
    AST_MEMCLR: assert property (CLK_EN && TX_CLEAR.memtemp && !INIT_COMPLETE_LOCK ##0 s_mem_quiet
        |=> !MEMORY_THERMAL_SUMMARY) else $error("memory flags survived clear");
    AST_LOCKSET: assert property (CLK_EN && INIT_LOCK_SET |=> INIT_COMPLETE_LOCK)
        else $error("lock not set");
    AST_LOCK: assert property (INIT_COMPLETE_LOCK |=> INIT_COMPLETE_LOCK)
        else $error("lock dropped without reset");
    AST_SUP: assert property (s_sup_held |=> SUPPLY_RECOVERING)
        else $error("supply fault not flagged");
endmodule : sfsr_checker
bind sfsr_regs sfsr_checker i_sfsr_checker (.MCLK, .RESET, .CLK_EN, .EVENTS, .TX_CLEAR, .U_OTP_WR_BUSY,
    .THERMAL_RANGE_FAULT, .INIT_LOCK_SET, .SUPPLY_FAULT, .INIT_COMPLETE_LOCK, .MEMORY_THERMAL_SUMMARY,
    .LINK_FAULT_SUMMARY, .SUPPLY_RECOVERING);
`default_nettype wire

// file: dv/sfsr_host.sv
// host model issuing single byte register reads
// assumes the caller sits 1 ns after an MCLK edge
`timescale 1ns/100ps
`default_nettype none
module sfsr_host (
    input  wire logic       MCLK,
    output var  logic       REG_RD,
    output var  logic [7:0] REG_ADDR,
    input  wire logic [7:0] REG_RDATA
);
    // ********
    // read cycle
    // ********
    initial begin
        REG_RD   = 1'b0;
        REG_ADDR = 8'hff;
    end
    // idle address inverted so a stale one never decodes; supply flags never read
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge MCLK) #1;
        REG_RD   = 1'b1;
        REG_ADDR = a;
        @(posedge MCLK) #1;
        REG_RD   = 1'b0;
        REG_ADDR = ~a;
        d        = REG_RDATA;
    endtask : rd
endmodule : sfsr_host
`default_nettype wire

// file: dv/tb_top.sv
// self-checking bench for the fault status register bank
// assumes sfsr_host as the reader; inputs move 1 ns after MCLK rises
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic                  mclk = 1'b0;
    logic                  reset = 1'b1;
    logic                  clk_en = 1'b1;
    sfsr_pkg::sfsr_event_s ev = '0;
    sfsr_pkg::sfsr_txclr_s txc = '0;
    logic                  busy = 1'b0;
    logic                  therm = 1'b0;
    logic [7:0]            temp = 8'h00;
    logic                  tvld = 1'b0;
    logic                  lset = 1'b0;
    logic [63:0]           user = 64'h0;
    logic                  sup = 1'b0;
    logic                  rd, lock, mts, lfs, recov;
    logic [7:0]            addr, rdata, d, a;
    logic [31:0]           seed = 32'h3cdb;
    int                    num_errors = 0;
    int                    n_tests = 0;
    always #5 mclk = ~mclk;
    sfsr_regs i_sfsr_regs (.MCLK(mclk), .RESET(reset), .CLK_EN(clk_en), .REG_RD(rd), .REG_ADDR(addr),
        .REG_RDATA(rdata), .EVENTS(ev), .TX_CLEAR(txc), .U_OTP_WR_BUSY(busy), .THERMAL_RANGE_FAULT(therm),
        .DIE_TEMP(temp), .DIE_TEMP_VALID(tvld), .INIT_LOCK_SET(lset), .USER_REGS(user), .SUPPLY_FAULT(sup),
        .INIT_COMPLETE_LOCK(lock), .MEMORY_THERMAL_SUMMARY(mts), .LINK_FAULT_SUMMARY(lfs),
        .SUPPLY_RECOVERING(recov));
    sfsr_host i_sfsr_host (.MCLK(mclk), .REG_RD(rd), .REG_ADDR(addr), .REG_RDATA(rdata));
    // ********
    // helpers
    // ********
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    function automatic logic [7:0] bitv(input int b);
        return 8'h01 << b;
    endfunction : bitv
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : tick
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic rchk(input logic [7:0] ra, input logic [7:0] exp);
        i_sfsr_host.rd(ra, d);
        chk("read data", d, exp);
    endtask : rchk
    // k selects factory, user or thermal source for a one cycle event
    task automatic pulse(input int k);
        ev.f_otp_fault = (k == 0);
        ev.u_otp_fault = (k == 1);
        therm          = (k == 2);
        tick(1);
        ev    = '0;
        therm = 1'b0;
    endtask : pulse
    task automatic print_verdict;
        $display("checks %0d errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : print_verdict
    // ********
    // sequence
    // ********
    initial begin
        #200000;
        num_errors++;
        print_verdict();
    end
    initial begin
        tick(10);
        reset = 1'b0;
        rchk(sfsr_pkg::SFSR_OFS_MEMTEMP, 8'h00);
        rchk(sfsr_pkg::SFSR_OFS_LINK, 8'h00);
        rchk(sfsr_pkg::SFSR_OFS_THERMAL, 8'h00);
        rchk(sfsr_pkg::SFSR_OFS_SUMMARY, 8'h00);
        for (int k = 0; k < 3; k++) begin
            a = (k == 0) ? bitv(7) : (k == 1) ? bitv(6) : bitv(2);
            pulse(k);
            chk("mem summary", {7'h0, mts}, 8'h01);
            rchk(sfsr_pkg::SFSR_OFS_MEMTEMP, a);
            chk("mem summary", {7'h0, mts}, 8'h00);
            rchk(sfsr_pkg::SFSR_OFS_MEMTEMP, 8'h00);
            pulse(k);
            txc.memtemp = 1'b1;
            tick(1);
            txc = '0;
            rchk(sfsr_pkg::SFSR_OFS_MEMTEMP, 8'h00);
        end
        busy = 1'b1;
        rchk(sfsr_pkg::SFSR_OFS_MEMTEMP, bitv(4));
        rchk(sfsr_pkg::SFSR_OFS_MEMTEMP, bitv(4));
        busy = 1'b0;
        rchk(sfsr_pkg::SFSR_OFS_MEMTEMP, 8'h00);
        ev.miso_mismatch = 1'b1;
        tick(1);
        ev = '0;
        rchk(sfsr_pkg::SFSR_OFS_LINK, bitv(7));
        rchk(sfsr_pkg::SFSR_OFS_LINK, 8'h00);
        ev.miso_mismatch = 1'b1;
        tick(1);
        ev = '0;
        chk("link summary", {7'h0, lfs}, 8'h01);
        txc.link = 1'b1;
        tick(1);
        txc = '0;
        chk("link summary", {7'h0, lfs}, 8'h00);
        rchk(sfsr_pkg::SFSR_OFS_LINK, 8'h00);
        // event lands on the very edge that takes the clearing read
        fork
            i_sfsr_host.rd(sfsr_pkg::SFSR_OFS_MEMTEMP, d);
            begin
                tick(1);
                ev.u_otp_fault = 1'b1;
                tick(1);
                ev = '0;
            end
        join
        rchk(sfsr_pkg::SFSR_OFS_MEMTEMP, bitv(6));
        clk_en = 1'b0;
        pulse(0);
        clk_en = 1'b1;
        rchk(sfsr_pkg::SFSR_OFS_MEMTEMP, 8'h00);
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            temp = seed[7:0];
            tvld = 1'b1;
            tick(1);
            tvld = 1'b0;
            rchk(sfsr_pkg::SFSR_OFS_THERMAL, seed[7:0]);
            a = seed[15:8];
            if (a != 8'h03 && a != 8'h04 && a != 8'h0e) rchk(a, 8'h00);
        end
        user = {seed, lfsr(seed)};
        lset = 1'b1;
        tick(1);
        lset = 1'b0;
        chk("lock", {7'h0, lock}, 8'h01);
        rchk(sfsr_pkg::SFSR_OFS_MEMTEMP, 8'h00);
        user[5] = ~user[5];
        tick(1);
        user[5] = ~user[5];
        rchk(sfsr_pkg::SFSR_OFS_MEMTEMP, bitv(5));
        rchk(sfsr_pkg::SFSR_OFS_MEMTEMP, 8'h00);
        sup = 1'b1;
        tick(10);
        sup = 1'b0;
        chk("recovering", {7'h0, recov}, 8'h01);
        tick(990);
        chk("recovering", {7'h0, recov}, 8'h01);
        tick(20);
        chk("recovering", {7'h0, recov}, 8'h00);
        // mid-run reset: lock and temperature must both return to zero
        reset = 1'b1;
        tick(2);
        reset = 1'b0;
        chk("lock", {7'h0, lock}, 8'h00);
        chk("summaries", {6'h0, mts, lfs}, 8'h00);
        rchk(sfsr_pkg::SFSR_OFS_THERMAL, 8'h00);
        print_verdict();
    end
endmodule : tb_top
`default_nettype wire
